// *** cc_partner.sv ***
/*
  port partner on the cc lines: attach, cable pull-down and vbus level
  as the toggle block's pin comparators see them.
  assumes the bench moves its controls just after rising clock edges.
*/
`timescale 1ns/1ps
module cc_partner (
  input  wire logic attach_i,
  input  wire logic ra_i,
  input  wire logic vbus_on_i,
  input  wire logic role_i,
  output logic      partner_attach_o,
  output logic      cable_pulldown_o,
  output logic      vbus_safe0v_o
);
  assign partner_attach_o = attach_i;
  // a cable pull-down only shows while the port sources
  assign cable_pulldown_o = ra_i & ~role_i;
  assign vbus_safe0v_o    = ~vbus_on_i;
endmodule // cc_partner

// *** drp_pkg.sv ***
/*
  constants for the dual-role toggle offload block: register indices,
  field positions, reset values and timing counts.
  assumes a 10 MHz core clock and a 32-bit classic Wishbone register bus.
*/
package drp_pkg;

  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_DRAIN_LEVEL = 16'h0886;
  localparam logic [15:0] IDX_DRAIN_TIME  = 16'h0888;
  localparam logic [15:0] IDX_TOGGLE_CTL  = 16'h0890;
  localparam logic [15:0] IDX_SEED        = 16'h0892;
  localparam logic [15:0] IDX_PERIOD      = 16'h0894;
  localparam logic [15:0] IDX_IRQ_STATUS  = 16'h08A4;
  localparam logic [15:0] IDX_IRQ_MASK    = 16'h08A5;

  // toggle control field positions
  localparam int BIT_EN        = 0;
  localparam int BIT_GEN_EN    = 1;
  localparam int POS_CURRENT   = 2;
  localparam int POS_SINK      = 4;
  localparam int BIT_INIT      = 7;
  localparam int BIT_ROLE      = 8;
  localparam int BIT_PD_DETECT = 9;
  localparam int BIT_ZERO_CHK  = 10;

  // interrupt status bits
  localparam int IRQ_FINISHED = 0;
  localparam int IRQ_DRAINED  = 1;

  // reset values; drain level, time and seed apply when the one-time memory is blank, the period at every reset
  localparam logic [9:0]  RST_DRAIN_LEVEL = 10'h041;
  localparam logic [7:0]  RST_DRAIN_TIME  = 8'h04;
  localparam logic [15:0] RST_SEED        = 16'hFFFF;
  localparam logic [7:0]  RST_PERIOD      = 8'h40;

  // random period window in ms
  localparam logic [7:0] PERIOD_MIN_MS  = 8'h32;
  localparam logic [7:0] PERIOD_SPAN_MS = 8'h33;

  // timing
  localparam int CLK_NS         = 100;
  localparam int CLK_HZ         = 10000000;
  localparam int GEN_HZ         = 10000;
  localparam int GEN_CYCLES     = CLK_HZ / GEN_HZ;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES      = MS_NS / CLK_NS;
  localparam int DRAIN_UNIT_MS  = 10;

  typedef enum logic [2:0] {
    TOG_OFF  = 3'b001,
    TOG_RUN  = 3'b010,
    TOG_DONE = 3'b100
  } toggle_state_t;

  typedef enum logic [1:0] {
    DRN_IDLE = 2'b01,
    DRN_BUSY = 2'b10
  } drain_state_t;

endpackage

// *** dual_role_toggle_offload.sv ***
/*
  dual-role toggle offload: vconn drain control, role toggling with a
  random period, Wishbone register file and interrupt.
  assumes otp values and drain requests come from logic on clk_i; the
  cc and vbus comparator levels come from pins and are synchronised here.
*/
// Implementation choice: the Wishbone slave port.
// Functional notes
// - a 10-bit vconn drain level ends vconn draining in standalone dfp mode.
// - the drain level loads from otp at reset, or 41h when otp is blank.
// - the vconn pin drains for an 8-bit time in 10 ms units, default 04h.
// - control bit 10 makes toggling check that vbus is below vsafe0v.
// - with bit 9 set, an ra/open detection halts toggling and flags finished.
// - read-only bit 8 shows the advertised role, zero dfp and one ufp.
// - bit 7 picks the role that starts each toggle period.
// - bits 6:4 select the pull-down applied while advertising ufp.
// - bits 3:2 select the rp current source level.
// - bit 1 enables the random generator, which steps at 10 kHz.
// - bit 0 enables or disables hardware role toggling.
// - a 16-bit seed is loaded into the generator when bit 1 becomes set; a zero seed loads ffffh instead.
// - the seed resets from otp serial bits 16:1, or ffffh when blank.
// - with the generator on, hardware rewrites the period each cycle.
// - an 8-bit period in 1 ms units, reset 40h, sets the toggle period.
`timescale 1ns/1ps
module dual_role_toggle_offload #(
  parameter int MS_CYCLES = drp_pkg::MS_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        otp_configured_i,
  input  wire logic [9:0]  otp_drain_level_i,
  input  wire logic [7:0]  otp_drain_time_i,
  input  wire logic [16:1] otp_serial_i,
  input  wire logic        partner_attach_i,
  input  wire logic        cable_pulldown_i,
  input  wire logic        vbus_safe0v_i,
  input  wire logic        standalone_dfp_i,
  input  wire logic        drain_start_i,
  input  wire logic [9:0]  vconn_level_i,
  output logic             advertised_role_o,
  output logic      [1:0]  source_current_level_o,
  output logic      [2:0]  sink_termination_sel_o,
  output logic             vconn_drain_o,
  output logic             toggle_finished_o,
  output logic             irq_o
);

  localparam logic [23:0] MS_LAST  = 24'(MS_CYCLES - 1);
  localparam logic [9:0]  GEN_LAST = 10'(drp_pkg::GEN_CYCLES - 1);

  // two-flop synchronisers for the comparator pins
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_raw;
  assign pin_raw = {vbus_safe0v_i, cable_pulldown_i, partner_attach_i};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_meta_reg[g] <= 1'b0;
          pin_sync_reg[g] <= 1'b0;
        end else begin
          pin_meta_reg[g] <= pin_raw[g];
          pin_sync_reg[g] <= pin_meta_reg[g];
        end
      end
    end
  endgenerate

  logic attach_s;
  logic pulldown_s;
  logic vbus_safe_s;
  assign attach_s    = pin_sync_reg[0];
  assign pulldown_s  = pin_sync_reg[1];
  assign vbus_safe_s = pin_sync_reg[2];

  // register storage
  logic [9:0]  drain_level_reg;
  logic [7:0]  drain_time_reg;
  logic        offload_en_reg;
  logic        gen_en_reg;
  logic [1:0]  current_reg;
  logic [2:0]  sink_sel_reg;
  logic        init_role_reg;
  logic        pd_detect_en_reg;
  logic        zero_chk_en_reg;
  logic [15:0] seed_reg;
  logic [7:0]  period_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_mask_reg;
  logic        role_reg;
  logic [15:0] lfsr_reg;
  logic        gen_en_d_reg;

  // wishbone slave: one wait state, ack for one cycle
  logic        ack_reg;
  logic        bus_req;
  logic        bus_wr;
  logic [15:0] bus_idx;
  assign bus_req = cyc_i && stb_i && !ack_reg;
  assign bus_wr  = bus_req && we_i;
  assign bus_idx = {2'b00, adr_i[15:2]};
  assign ack_o   = ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  logic [15:0] ctl_view;
  assign ctl_view = {5'h00, zero_chk_en_reg, pd_detect_en_reg, role_reg,
                     init_role_reg, sink_sel_reg, current_reg, gen_en_reg,
                     offload_en_reg};

  logic [31:0] rd_next;
  always_comb begin
    rd_next = 32'h0000_0000;
    case (bus_idx)
      drp_pkg::IDX_DRAIN_LEVEL: rd_next = {22'h00_0000, drain_level_reg};
      drp_pkg::IDX_DRAIN_TIME:  rd_next = {24'h00_0000, drain_time_reg};
      drp_pkg::IDX_TOGGLE_CTL:  rd_next = {16'h0000, ctl_view};
      drp_pkg::IDX_SEED:        rd_next = {16'h0000, seed_reg};
      drp_pkg::IDX_PERIOD:      rd_next = {24'h00_0000, period_reg};
      drp_pkg::IDX_IRQ_STATUS:  rd_next = {30'h0000_0000, irq_status_reg};
      drp_pkg::IDX_IRQ_MASK:    rd_next = {30'h0000_0000, irq_mask_reg};
      default:                  rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_o <= rd_next;
    end
  end

  // otp-backed registers: values captured by the synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drain_level_reg <= otp_configured_i ? otp_drain_level_i
                                          : drp_pkg::RST_DRAIN_LEVEL;
      drain_time_reg  <= otp_configured_i ? otp_drain_time_i
                                          : drp_pkg::RST_DRAIN_TIME;
      seed_reg        <= otp_configured_i ? otp_serial_i
                                          : drp_pkg::RST_SEED;
    end else if (bus_wr) begin
      if (bus_idx == drp_pkg::IDX_DRAIN_LEVEL) begin
        if (sel_i[0]) drain_level_reg[7:0] <= dat_i[7:0];
        if (sel_i[1]) drain_level_reg[9:8] <= dat_i[9:8];
      end
      if (bus_idx == drp_pkg::IDX_DRAIN_TIME && sel_i[0]) begin
        drain_time_reg <= dat_i[7:0];
      end
      if (bus_idx == drp_pkg::IDX_SEED) begin
        if (sel_i[0]) seed_reg[7:0]  <= dat_i[7:0];
        if (sel_i[1]) seed_reg[15:8] <= dat_i[15:8];
      end
    end
  end

  // toggle control fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offload_en_reg   <= 1'b0;
      gen_en_reg       <= 1'b0;
      current_reg      <= 2'b00;
      sink_sel_reg     <= 3'b000;
      init_role_reg    <= 1'b0;
      pd_detect_en_reg <= 1'b0;
      zero_chk_en_reg  <= 1'b0;
    end else if (bus_wr && bus_idx == drp_pkg::IDX_TOGGLE_CTL) begin
      if (sel_i[0]) begin
        offload_en_reg <= dat_i[drp_pkg::BIT_EN];
        gen_en_reg     <= dat_i[drp_pkg::BIT_GEN_EN];
        current_reg    <= dat_i[drp_pkg::POS_CURRENT +: 2];
        sink_sel_reg   <= dat_i[drp_pkg::POS_SINK +: 3];
        init_role_reg  <= dat_i[drp_pkg::BIT_INIT];
      end
      if (sel_i[1]) begin
        pd_detect_en_reg <= dat_i[drp_pkg::BIT_PD_DETECT];
        zero_chk_en_reg  <= dat_i[drp_pkg::BIT_ZERO_CHK];
      end
    end
  end

  // free-running 1 ms and 10 kHz ticks
  logic [23:0] ms_cnt_reg;
  logic [9:0]  gen_cnt_reg;
  logic        ms_tick;
  logic        gen_tick;
  assign ms_tick  = (ms_cnt_reg == MS_LAST);
  assign gen_tick = (gen_cnt_reg == GEN_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt_reg  <= 24'h00_0000;
      gen_cnt_reg <= 10'h000;
    end else begin
      ms_cnt_reg  <= ms_tick ? 24'h00_0000 : ms_cnt_reg + 24'h00_0001;
      gen_cnt_reg <= gen_tick ? 10'h000 : gen_cnt_reg + 10'h001;
    end
  end

  // pseudo-random generator, 16-bit fibonacci, taps 16 14 13 11
  logic lfsr_fb;
  assign lfsr_fb = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_reg     <= drp_pkg::RST_SEED;
      gen_en_d_reg <= 1'b0;
    end else begin
      gen_en_d_reg <= gen_en_reg;
      if (gen_en_reg && !gen_en_d_reg) begin
        // an all-zero seed would lock the generator
        lfsr_reg <= (seed_reg == 16'h0000) ? drp_pkg::RST_SEED
                                           : seed_reg;
      end else if (gen_en_reg && gen_tick) begin
        lfsr_reg <= {lfsr_reg[14:0], lfsr_fb};
      end
    end
  end

  // map the low byte into the 50..100 ms window
  logic [15:0] map_prod;
  logic [7:0]  mapped_period;
  assign map_prod      = lfsr_reg[7:0] * drp_pkg::PERIOD_SPAN_MS;
  assign mapped_period = drp_pkg::PERIOD_MIN_MS + map_prod[15:8];

  // role toggling
  drp_pkg::toggle_state_t tog_state_reg;
  logic [7:0] phase_ms_reg;
  logic       half_reg;
  logic [7:0] half_ms;
  logic       phase_end;
  logic       next_role;
  logic       hold_for_vbus;
  logic       cycle_start;
  logic       stop_detect;

  assign half_ms   = (period_reg[7:1] == 7'h00) ? 8'h01
                                                : {1'b0, period_reg[7:1]};
  assign phase_end = ms_tick && (phase_ms_reg + 8'h01 >= half_ms);
  assign next_role = half_reg ? init_role_reg : ~init_role_reg;
  assign hold_for_vbus = zero_chk_en_reg && !next_role
                         && !vbus_safe_s;
  assign cycle_start = (tog_state_reg == drp_pkg::TOG_RUN) && phase_end
                       && half_reg && !hold_for_vbus;
  assign stop_detect = attach_s
                       || (pd_detect_en_reg && pulldown_s);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tog_state_reg <= drp_pkg::TOG_OFF;
      role_reg      <= 1'b0;
      half_reg      <= 1'b0;
      phase_ms_reg  <= 8'h00;
    end else begin
      case (tog_state_reg)
        drp_pkg::TOG_OFF: begin
          phase_ms_reg <= 8'h00;
          half_reg     <= 1'b0;
          role_reg     <= init_role_reg;
          if (offload_en_reg) begin
            tog_state_reg <= drp_pkg::TOG_RUN;
          end
        end
        drp_pkg::TOG_RUN: begin
          if (!offload_en_reg) begin
            tog_state_reg <= drp_pkg::TOG_OFF;
          end else if (stop_detect) begin
            tog_state_reg <= drp_pkg::TOG_DONE;
          end else if (phase_end && !hold_for_vbus) begin
            phase_ms_reg <= 8'h00;
            half_reg     <= ~half_reg;
            role_reg     <= next_role;
          end else if (ms_tick && !phase_end) begin
            phase_ms_reg <= phase_ms_reg + 8'h01;
          end
        end
        drp_pkg::TOG_DONE: begin
          if (!offload_en_reg) begin
            tog_state_reg <= drp_pkg::TOG_OFF;
          end
        end
        default: tog_state_reg <= drp_pkg::TOG_OFF;
      endcase
    end
  end

  // toggle period: software value, rewritten by hardware each cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= drp_pkg::RST_PERIOD;
    end else if (cycle_start && gen_en_reg) begin
      period_reg <= mapped_period;
    end else if (bus_wr && bus_idx == drp_pkg::IDX_PERIOD && sel_i[0]) begin
      period_reg <= dat_i[7:0];
    end
  end

  // vconn drain sequencer
  drp_pkg::drain_state_t drn_state_reg;
  logic [11:0] drain_ms_reg;
  logic [11:0] drain_limit;
  logic        drain_end;
  assign drain_limit = 12'(drain_time_reg) * 12'(drp_pkg::DRAIN_UNIT_MS);
  assign drain_end   = (ms_tick && drain_ms_reg + 12'h001 >= drain_limit)
                       || (standalone_dfp_i
                           && vconn_level_i <= drain_level_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drn_state_reg <= drp_pkg::DRN_IDLE;
      drain_ms_reg  <= 12'h000;
    end else begin
      case (drn_state_reg)
        drp_pkg::DRN_IDLE: begin
          drain_ms_reg <= 12'h000;
          if (drain_start_i) begin
            drn_state_reg <= drp_pkg::DRN_BUSY;
          end
        end
        drp_pkg::DRN_BUSY: begin
          if (drain_end) begin
            drn_state_reg <= drp_pkg::DRN_IDLE;
          end else if (ms_tick) begin
            drain_ms_reg <= drain_ms_reg + 12'h001;
          end
        end
        default: drn_state_reg <= drp_pkg::DRN_IDLE;
      endcase
    end
  end

  // interrupt status: set wins over a write-one clear
  logic [1:0] irq_set;
  assign irq_set[drp_pkg::IRQ_FINISHED] =
    (tog_state_reg == drp_pkg::TOG_RUN) && offload_en_reg && stop_detect;
  assign irq_set[drp_pkg::IRQ_DRAINED] =
    (drn_state_reg == drp_pkg::DRN_BUSY) && drain_end;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg <= 2'b00;
      irq_mask_reg   <= 2'b00;
    end else begin
      if (bus_wr && bus_idx == drp_pkg::IDX_IRQ_STATUS && sel_i[0]) begin
        irq_status_reg <= (irq_status_reg & ~dat_i[1:0]) | irq_set;
      end else begin
        irq_status_reg <= irq_status_reg | irq_set;
      end
      if (bus_wr && bus_idx == drp_pkg::IDX_IRQ_MASK && sel_i[0]) begin
        irq_mask_reg <= dat_i[1:0];
      end
    end
  end

  // outputs
  assign irq_o                  = |(irq_status_reg & irq_mask_reg);
  assign advertised_role_o      = role_reg;
  assign toggle_finished_o      = (tog_state_reg == drp_pkg::TOG_DONE);
  assign vconn_drain_o          = (drn_state_reg == drp_pkg::DRN_BUSY);
  assign source_current_level_o = role_reg ? 2'b00 : current_reg;
  assign sink_termination_sel_o = sink_sel_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_level_reset: assert property (
    $fell(rst_i) |-> drain_level_reg == ($past(otp_configured_i)
      ? $past(otp_drain_level_i) : drp_pkg::RST_DRAIN_LEVEL))
    else $error("drain level reset value wrong");

  chk_drain_bound: assert property (
    vconn_drain_o |-> (drain_limit == 12'h000) ? drain_ms_reg == 12'h000
                                               : drain_ms_reg < drain_limit)
    else $error("vconn drain ran past its time");

  chk_level_stop: assert property (
    vconn_drain_o && standalone_dfp_i && vconn_level_i <= drain_level_reg
    |=> !vconn_drain_o)
    else $error("drain did not stop at level");

  chk_zero_hold: assert property (
    $fell(role_reg) && (tog_state_reg == drp_pkg::TOG_RUN)
    && $past(zero_chk_en_reg) |-> $past(vbus_safe_s))
    else $error("dfp entered with vbus above vsafe0v");

  sequence s_ra_seen;
    (tog_state_reg == drp_pkg::TOG_RUN) && offload_en_reg && pulldown_s;
  endsequence

  chk_ra_halt: assert property (
    s_ra_seen ##0 pd_detect_en_reg |=> toggle_finished_o
      ##1 irq_status_reg[drp_pkg::IRQ_FINISHED])
    else $error("ra detect did not halt toggling");

  chk_ra_ignore: assert property (
    s_ra_seen ##0 (!pd_detect_en_reg && !attach_s) |=> !toggle_finished_o)
    else $error("ra detect halted while disabled");

  chk_start_role: assert property (
    (tog_state_reg == drp_pkg::TOG_OFF) ##1
    (tog_state_reg == drp_pkg::TOG_RUN) |-> role_reg == $past(init_role_reg))
    else $error("toggle did not start in initial role");

  chk_seed_load: assert property (
    $rose(gen_en_reg) && seed_reg != 16'h0000 |=> lfsr_reg == $past(seed_reg))
    else $error("seed not loaded on enable");

  chk_gen_rate: assert property (
    gen_en_reg && gen_en_d_reg && !gen_tick |=> $stable(lfsr_reg))
    else $error("generator stepped off the 10 kHz tick");

  chk_period_map: assert property (
    cycle_start && gen_en_reg |=> period_reg >= 8'h32 && period_reg <= 8'h64)
    else $error("random period outside window");

  chk_offload_off: assert property (
    !offload_en_reg |=> tog_state_reg == drp_pkg::TOG_OFF)
    else $error("toggling continued while disabled");

endmodule // dual_role_toggle_offload

// *** dual_role_toggle_offload_test.sv ***
/*
  self-checking bench for the dual-role toggle offload block.
  assumes the block answers on classic wishbone and a 1 ms tick of 20
  clocks, set through the block's tick parameter.
*/
`timescale 1ns/1ps
module dual_role_toggle_offload_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o, q;
  logic        ack_o, role, fin, drain, irq, pa, cp, vs;
  logic [1:0]  cur;
  logic [2:0]  sink;
  logic [2:0]  mon;
  logic        otp_cfg = 1'b0, attach = 1'b0, ra = 1'b0, vbus_on = 1'b0;
  logic        dfp = 1'b0, start = 1'b0;
  logic [9:0]  otp_lvl = 10'h000, vlev = 10'h100;
  logic [7:0]  otp_time = 8'h00;
  logic [16:1] otp_ser = 16'h0000;
  int          errors = 0, checks = 0, n;

  always #50 clk_i = ~clk_i;
  assign mon = {drain, fin, role};

  dual_role_toggle_offload #(.MS_CYCLES(20)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .otp_configured_i(otp_cfg), .otp_drain_level_i(otp_lvl),
    .otp_drain_time_i(otp_time), .otp_serial_i(otp_ser),
    .partner_attach_i(pa), .cable_pulldown_i(cp), .vbus_safe0v_i(vs),
    .standalone_dfp_i(dfp), .drain_start_i(start), .vconn_level_i(vlev),
    .advertised_role_o(role), .source_current_level_o(cur),
    .sink_termination_sel_o(sink), .vconn_drain_o(drain),
    .toggle_finished_o(fin), .irq_o(irq));

  cc_partner partner (
    .attach_i(attach), .ra_i(ra), .vbus_on_i(vbus_on), .role_i(role),
    .partner_attach_o(pa), .cable_pulldown_o(cp), .vbus_safe0v_o(vs));

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i[13:0], 2'b00};
    dat <= d;
    sel <= 4'hf;
    // ack and read data are judged at the rising edge itself
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      errors++;
      end_sim();
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // wait at falling edges for one monitored output to reach v
  task automatic wait_on(input int w, input logic v, input int lim);
    n = 0;
    while (n < lim && mon[w] !== v) begin
      @(negedge clk_i);
      n++;
    end
    if (mon[w] !== v) begin
      errors++;
      end_sim();
    end
  endtask

  task automatic pulse_start();
    @(posedge clk_i);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask

  task automatic t_reset();
    logic [15:0] ri [5];
    logic [31:0] rv [5];
    ri = '{drp_pkg::IDX_DRAIN_LEVEL, drp_pkg::IDX_DRAIN_TIME,
           drp_pkg::IDX_SEED, drp_pkg::IDX_PERIOD, drp_pkg::IDX_TOGGLE_CTL};
    rv = '{32'h0000_0041, 32'h0000_0004, 32'h0000_ffff, 32'h0000_0040,
           32'h0000_0000};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ri[i], 32'h0000_0000);
      chk(q, rv[i]);
    end
    bus(1'b1, 16'h0800, 32'h0000_1234);
    bus(1'b0, 16'h0800, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("reset test done");
  endtask

  task automatic t_fields();
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {9'h000, i[2:0], i[1:0], 2'b00};
      bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, {16'h0000, 16'hf900 | v});
      chk(sink, i[2:0]);
      chk(cur, i[1:0]);
      bus(1'b0, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0000);
      chk(q, v);
    end
    $display("field test done");
  endtask

  task automatic t_toggle();
    bus(1'b1, drp_pkg::IDX_PERIOD, 32'h0000_0032);
    vbus_on <= 1'b1;
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0081);
    @(negedge clk_i);
    chk(role, 1'b1);
    bus(1'b0, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0000);
    chk(q[8], 1'b1);
    wait_on(0, 1'b0, 600);
    chk(n > 465 && n < 505, 1'b1);
    wait_on(0, 1'b1, 600);
    chk(n > 495 && n < 505, 1'b1);
    bus(1'b0, drp_pkg::IDX_PERIOD, 32'h0000_0000);
    chk(q, 32'h0000_0032);
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0481);
    repeat (600) @(negedge clk_i);
    chk(role, 1'b1);
    @(posedge clk_i);
    vbus_on <= 1'b0;
    // two sync flops plus up to one 1 ms tick before the held flip
    wait_on(0, 1'b0, 30);
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0000);
    $display("toggle test done");
  endtask

  task automatic t_detect();
    ra <= 1'b1;
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0001);
    chk(role, 1'b0);
    repeat (100) @(negedge clk_i);
    chk(fin, 1'b0);
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0000);
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0201);
    wait_on(1, 1'b1, 10);
    repeat (600) @(negedge clk_i);
    chk(role, 1'b0);
    bus(1'b1, drp_pkg::IDX_IRQ_MASK, 32'h0000_0000);
    @(negedge clk_i);
    chk(irq, 1'b0);
    bus(1'b1, drp_pkg::IDX_IRQ_MASK, 32'h0000_0003);
    @(negedge clk_i);
    chk(irq, 1'b1);
    bus(1'b0, drp_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
    chk(q[0], 1'b1);
    ra <= 1'b0;
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0000);
    bus(1'b1, drp_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    @(negedge clk_i);
    chk(irq, 1'b0);
    $display("detect test done");
  endtask

  task automatic t_drain();
    bus(1'b1, drp_pkg::IDX_DRAIN_TIME, 32'h0000_0001);
    pulse_start();
    wait_on(2, 1'b1, 4);
    wait_on(2, 1'b0, 260);
    chk(n >= 178 && n <= 222, 1'b1);
    bus(1'b0, drp_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
    chk(q[1], 1'b1);
    bus(1'b1, drp_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
    dfp <= 1'b1;
    pulse_start();
    wait_on(2, 1'b1, 4);
    repeat (50) @(negedge clk_i);
    chk(drain, 1'b1);
    @(posedge clk_i);
    vlev <= 10'h041;
    wait_on(2, 1'b0, 4);
    dfp <= 1'b0;
    $display("drain test done");
  endtask

  task automatic t_gen();
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0083);
    @(negedge clk_i);
    wait_on(0, 1'b0, 2100);
    wait_on(0, 1'b1, 2100);
    bus(1'b0, drp_pkg::IDX_PERIOD, 32'h0000_0000);
    chk(q >= 32'h0000_0032 && q <= 32'h0000_0064, 1'b1);
    // seed ffffh, at most one step: low byte fe..ff maps to 100 ms
    chk(q, 32'h0000_0064);
    bus(1'b1, drp_pkg::IDX_TOGGLE_CTL, 32'h0000_0000);
    $display("generator test done");
  endtask

  task automatic t_otp();
    @(posedge clk_i);
    otp_cfg <= 1'b1;
    otp_lvl <= 10'h2a5;
    otp_time <= 8'h9c;
    otp_ser <= 16'h5a3c;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, drp_pkg::IDX_DRAIN_LEVEL, 32'h0000_0000);
    chk(q, 32'h0000_02a5);
    bus(1'b0, drp_pkg::IDX_DRAIN_TIME, 32'h0000_0000);
    chk(q, 32'h0000_009c);
    bus(1'b0, drp_pkg::IDX_SEED, 32'h0000_0000);
    chk(q, 32'h0000_5a3c);
    $display("otp test done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fields();
    t_toggle();
    t_detect();
    t_drain();
    t_gen();
    t_otp();
    end_sim();
  end
endmodule // dual_role_toggle_offload_test
